// ===== rtl/pport_pkg.sv
// Contract
// [R01] port latch updated at latch_write_phase
// [R02] drivers sample latch in phase one only
// [R03] strong_pullup pulse two periods on rise
// [R04] ports 1-3 weak high, port 0 low-only
// [R05] expanded bus drives address and data
// [R06] expanded bus keeps port 2, fills port 0
// [R07] latched one makes pin an input
// [R08] normal read returns pin levels
// [R09] read-modify-write reads the latch
// [R10] host writes input, reads output or status
// [R11] both host buffers share port 0 address
// [R12] status register at its own address
// [R13] host_port_enable set switches ports to host
// [R14] port 0 is host data bus
// [R15] command_select on port 2 bit 0
// [R16] active-low chip select on bit 1
// [R17] active-low read strobe on bit 2
// [R18] active-low write strobe on bit 3
// [R19] out_buffer_full driven on bit 4
// [R20] in_buffer_empty_n driven on bit 5
// [R21] dma_request bit 6, dma_grant_n bit 7
// [R22] reset loads every latch with ones
// [R23] input full sets on host write, clears on read; in_buffer_empty_n here clears on the read that empties the input fifo or when host mode ends
// [R24] output full sets on cpu write, clears on host read
// [R25] command_select captured on valid host write
// [R26] enable cleared restores plain port behaviour
package pport_pkg;
    // machine cycle of twelve phases; even counts are clock phase one
    localparam logic [3:0] PHASE_LAST = 4'h0B;
    localparam logic [3:0] LATCH_WRITE_PHASE = 4'h0B;
    // strong pull-up time in oscillator periods, one clock per period
    localparam int unsigned PULLUP_OSC_PERIODS = 2;
    localparam int unsigned CLKS_PER_OSC = 1;
    localparam logic [1:0] PULLUP_CYCLES = 2'(PULLUP_OSC_PERIODS * CLKS_PER_OSC);
    // special-register addresses, index k is port k
    localparam logic [3:0][7:0] PORT_ADDR = {8'hB0, 8'hA0, 8'h90, 8'h80};
    localparam logic [7:0] ADDR_HOST_CTRL = 8'hD8;
    localparam logic [7:0] ADDR_HOST_STAT = 8'hDA;
    // control fields
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_DMA_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // status fields
    localparam int unsigned STAT_OBF = 0;
    localparam int unsigned STAT_IBF = 1;
    localparam int unsigned STAT_F0 = 2;
    localparam int unsigned STAT_IA0 = 3;
    localparam logic [7:0] STAT_WR_MASK = 8'hF4;
    // host pins on port 2
    localparam int unsigned HP_A0 = 0;
    localparam int unsigned HP_CS_N = 1;
    localparam int unsigned HP_RD_N = 2;
    localparam int unsigned HP_WR_N = 3;
    localparam int unsigned HP_OBF = 4;
    localparam int unsigned HP_IBE_N = 5;
    localparam int unsigned HP_DRQ = 6;
    localparam int unsigned HP_DMA_GRANT_N_N = 7;
    localparam logic [7:0] HP_OUT_MASK = 8'h70;
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam int unsigned IN_FIFO_DEPTH = 32;

    // cpu access to special registers
    typedef struct packed {
        logic wr;
        logic rd;
        logic rmw;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // expanded memory bus request from the core
    typedef struct packed {
        logic act;
        logic addr_phase;
        logic data_out;
        logic [15:0] addr;
        logic [7:0] wdata;
    } xbus_t;
endpackage

// ===== rtl/parallel_port_host_slave_mode.sv
`timescale 1ns/1ps

// plain fifo, first word shown on the output while valid
module pport_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    // fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp; // extra bit tells full from empty
    logic [AW:0] rp;
    wire push = i_valid & o_ready;
    wire pop = o_valid & i_ready;

    assign o_ready = (wp[AW] == rp[AW]) || (wp[AW-1:0] != rp[AW-1:0]);
    assign o_valid = wp != rp;
    assign o_data = mem[rp[AW-1:0]];

    // storage needs no reset
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= i_data;
        end
    end

    // pointers
    always_ff @(posedge i_clk) begin
        if (i_rst || i_flush) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= wp + (AW+1)'(push);
            rp <= rp + (AW+1)'(pop);
        end
    end
endmodule

module parallel_port_host_slave_mode #(
    parameter int unsigned FIFO_DEPTH = pport_pkg::IN_FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // core special-register access
    input pport_pkg::sfr_req_t i_sfr,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_rvalid,
    // core expanded memory bus
    input pport_pkg::xbus_t i_xbus,
    // port pins, index is port number
    input wire logic [3:0][7:0] i_pin,
    output logic [3:0][7:0] o_pin_out,
    output logic [3:0][7:0] o_pin_oe,
    output logic [3:0][7:0] o_strong_pullup
);
    import pport_pkg::*;

    logic [3:0] phase; // machine-cycle phase counter
    logic pend_valid; // write waiting for its latch slot
    logic [7:0] pend_addr;
    logic [7:0] pend_data;
    logic [3:0][7:0] latch; // port latches
    logic [3:0][7:0] drv; // what drivers last sampled
    logic [3:0][7:0] pu_mask; // bits in strong pull-up
    logic [1:0] pu_cnt;
    logic [7:0] ctrl; // host_port_control
    logic [7:0] out_buf; // host_output_buffer
    logic out_buffer_full;
    logic f0;
    logic ia0;
    logic [3:0] user_stat;
    logic [7:0] prev_hp; // port 2 pins one clock ago
    logic [7:0] prev_p0;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;

    // timing slots
    wire latch_slot = phase == LATCH_WRITE_PHASE;
    wire drive_slot = ~phase[0];
    wire apply = latch_slot & pend_valid;
    wire slave = ctrl[CTRL_ENABLE_BIT];

    // host pin decode
    wire [7:0] hp = i_pin[2];
    wire host_sel = ~prev_hp[HP_CS_N] | ~prev_hp[HP_DMA_GRANT_N_N];
    wire host_rd_now = slave & ~hp[HP_RD_N] & (~hp[HP_CS_N] | ~hp[HP_DMA_GRANT_N_N]); // [R17]
    wire host_rd_stat = ~hp[HP_CS_N] & hp[HP_A0] & hp[HP_DMA_GRANT_N_N]; // [R15]
    wire host_wr_end = slave & ~prev_hp[HP_WR_N] & hp[HP_WR_N] & ~prev_hp[HP_CS_N]; // [R16] [R18]
    wire host_wr_ok = host_wr_end & fifo_in_ready;
    wire host_rd_end = slave & ~prev_hp[HP_RD_N] & hp[HP_RD_N] & host_sel
        & ~(prev_hp[HP_A0] & prev_hp[HP_DMA_GRANT_N_N]);
    wire obf_set = apply & slave & (pend_addr == PORT_ADDR[0]); // [R11]
    wire cpu_pop = i_sfr.rd & slave & (i_sfr.addr == PORT_ADDR[0]); // [R11]
    wire in_buffer_empty_n = fifo_out_valid;
    wire [7:0] status = {user_stat, ia0, f0, in_buffer_empty_n, out_buffer_full};

    // phase counter runs free
    always_ff @(posedge i_clk) begin
        if (i_rst || phase == PHASE_LAST) begin
            phase <= '0;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    // cpu writes wait for the latch slot of the cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_valid <= 1'b0;
            pend_addr <= 8'h00;
            pend_data <= 8'h00;
        end else if (i_sfr.wr) begin
            pend_valid <= 1'b1;
            pend_addr <= i_sfr.addr;
            pend_data <= i_sfr.wdata;
        end else if (latch_slot) begin
            pend_valid <= 1'b0;
        end
    end

    // latches and phase-one sampling per port
    for (genvar k = 0; k < 4; k++) begin : g_port
        wire wr_hit = apply & (pend_addr == PORT_ADDR[k]) & ~(slave && k == 0);
        wire xb_fill = (k == 0) && i_xbus.act && !slave;
        wire [7:0] rise = latch[k] & ~drv[k];

        // latch update
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                latch[k] <= LATCH_RESET; // [R22]
            end else if (xb_fill) begin
                latch[k] <= LATCH_RESET; // [R06]
            end else if (wr_hit) begin
                latch[k] <= pend_data; // [R01] [R09]
            end
        end

        // drivers follow the latch only in phase one
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                drv[k] <= LATCH_RESET;
                pu_mask[k] <= 8'h00;
            end else if (drive_slot) begin
                drv[k] <= latch[k]; // [R02]
                pu_mask[k] <= (k == 0) ? 8'h00 : rise; // [R03]
            end
        end
    end

    // shared pull-up timer, reloaded whenever a new rise appears
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pu_cnt <= 2'h0;
        end else if (drive_slot) begin
            pu_cnt <= (|pu_mask_next()) ? PULLUP_CYCLES : 2'h0; // [R03]
        end else if (pu_cnt != 2'h0) begin
            pu_cnt <= pu_cnt - 2'h1;
        end
    end

    function automatic logic [31:0] pu_mask_next();
        pu_mask_next = '0;
        for (int k = 1; k < 4; k++) begin
            pu_mask_next[k*8 +: 8] = latch[k] & ~drv[k];
        end
    endfunction

    // host_port_control, written from the latch slot
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl <= CTRL_RESET;
        end else if (apply && pend_addr == ADDR_HOST_CTRL) begin
            ctrl <= pend_data; // [R13] [R26]
        end
    end

    // cpu-written status bits, cleared outside host mode
    always_ff @(posedge i_clk) begin
        if (i_rst || !slave) begin
            f0 <= 1'b0;
            user_stat <= 4'h0;
        end else if (apply && pend_addr == ADDR_HOST_STAT) begin
            f0 <= pend_data[STAT_F0]; // [R12]
            user_stat <= pend_data[7:4];
        end
    end

    // output buffer and its full flag; a cpu write beats a host read
    always_ff @(posedge i_clk) begin
        if (i_rst || !slave) begin
            out_buffer_full <= 1'b0;
            out_buf <= 8'h00;
        end else if (obf_set) begin
            out_buffer_full <= 1'b1; // [R24]
            out_buf <= pend_data;
        end else if (host_rd_end) begin
            out_buffer_full <= 1'b0; // [R24]
        end
    end

    // command_select of the last accepted host write
    always_ff @(posedge i_clk) begin
        if (i_rst || !slave) begin
            ia0 <= 1'b0;
        end else if (host_wr_ok) begin
            ia0 <= prev_hp[HP_A0]; // [R25]
        end
    end

    // pin history for strobe edges; data is taken while the strobe was low
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_hp <= 8'hFF;
            prev_p0 <= 8'h00;
        end else begin
            prev_hp <= hp;
            prev_p0 <= i_pin[0];
        end
    end

    // input buffer; a full fifo locks out further host writes
    pport_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_in_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_flush(~slave),
        .i_valid(host_wr_end), // [R10] [R23]
        .i_data(prev_p0),
        .o_ready(fifo_in_ready),
        .o_valid(fifo_out_valid),
        .o_data(fifo_out_data),
        .i_ready(cpu_pop) // [R23]
    );

    // read data selection
    wire [1:0] port_idx = i_sfr.addr[5:4];
    wire port_hit = (i_sfr.addr[7:6] == 2'b10) && (i_sfr.addr[3:0] == 4'h0);
    wire [7:0] port_val = i_sfr.rmw ? latch[port_idx] : i_pin[port_idx]; // [R08] [R09]
    wire [7:0] rd_sel = cpu_pop ? fifo_out_data :
        port_hit ? port_val :
        (i_sfr.addr == ADDR_HOST_CTRL) ? ctrl :
        (i_sfr.addr == ADDR_HOST_STAT) ? status : 8'h00; // [R12]

    // read data registered, one clock after the request
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sfr_rdata <= 8'h00;
            o_sfr_rvalid <= 1'b0;
        end else begin
            o_sfr_rdata <= i_sfr.rd ? rd_sel : o_sfr_rdata;
            o_sfr_rvalid <= i_sfr.rd;
        end
    end

    // pin drive; host mode first, then expanded bus, then plain latch
    wire [7:0] hp_out = {1'b0, ctrl[CTRL_DMA_BIT] & out_buffer_full, in_buffer_empty_n, out_buffer_full, 4'h0}; // [R19] [R20] [R21]
    wire [7:0] p0_host = host_rd_stat ? status : out_buf; // [R10]
    wire [7:0] p0_xbus = i_xbus.addr_phase ? i_xbus.addr[7:0] : i_xbus.wdata;
    wire p0_xbus_oe = i_xbus.addr_phase | i_xbus.data_out;

    // pull-up timer running for any port
    wire [7:0] pu_on = {8{pu_cnt != 2'h0}};
    // per-port boost; port 2 has none while the pins serve a bus
    wire [7:0] sp1 = pu_mask[1] & pu_on; // [R03]
    wire [7:0] sp2 = (slave | i_xbus.act) ? 8'h00 : pu_mask[2] & pu_on; // [R03]
    wire [7:0] sp3 = pu_mask[3] & pu_on; // [R03]
    // port 0: host data, bus address or data, else low-only latch drive
    wire [7:0] p0_out = slave ? p0_host : i_xbus.act ? p0_xbus : drv[0]; // [R14] [R05]
    wire [7:0] p0_oe = slave ? {8{host_rd_now}} : i_xbus.act ? {8{p0_xbus_oe}} : ~drv[0]; // [R04] [R07]
    // port 2: host flags, upper address, else latch
    wire [7:0] p2_out = slave ? hp_out : i_xbus.act ? i_xbus.addr[15:8] : drv[2]; // [R05] [R13]
    wire [7:0] p2_oe = slave ? HP_OUT_MASK : i_xbus.act ? 8'hFF : ~drv[2] | sp2; // [R21]

    // whole-vector drives, one driver per output
    assign o_pin_out = {drv[3], p2_out, drv[1], p0_out}; // [R04]
    assign o_pin_oe = {~drv[3] | sp3, p2_oe, ~drv[1] | sp1, p0_oe}; // [R07]
    assign o_strong_pullup = {sp3, sp2, sp1, 8'h00}; // [R03]

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_p1_write;
        apply && pend_addr == PORT_ADDR[1];
    endsequence

    a_latch_in_slot: assert property ($changed(latch[1]) |-> $past(latch_slot)) // [R01]
        else $error("port 1 latch changed outside its slot");
    a_pin_after_write: assert property (s_p1_write |-> ##2 o_pin_out[1] == $past(pend_data, 2)) // [R02]
        else $error("pin did not follow latch two clocks later");
    a_pullup_width: assert property ($rose(o_strong_pullup[1][0]) |-> o_strong_pullup[1][0] [*2]) // [R03]
        else $error("strong pull-up pulse too short");
    a_p0_low_only: assert property (!slave && !i_xbus.act |-> (o_pin_oe[0] & o_pin_out[0]) == 8'h00) // [R04]
        else $error("port 0 drove a one in plain mode");
    a_xbus_address: assert property (i_xbus.act && !slave |-> o_pin_out[2] == i_xbus.addr[15:8]) // [R05]
        else $error("port 2 does not carry upper address");
    a_xbus_fill: assert property (i_xbus.act && !slave |=> latch[0] == LATCH_RESET) // [R06]
        else $error("port 0 latch not filled with ones");
    a_read_pins: assert property (i_sfr.rd && !i_sfr.rmw && i_sfr.addr == PORT_ADDR[1]
        |=> o_sfr_rdata == $past(i_pin[1])) // [R08]
        else $error("normal read did not return pins");
    a_read_latch: assert property (i_sfr.rd && i_sfr.rmw && i_sfr.addr == PORT_ADDR[3]
        |=> o_sfr_rdata == $past(latch[3])) // [R09]
        else $error("modify read did not return latch");
    a_obf_cycle: assert property (obf_set |=> out_buffer_full ##0 o_pin_out[2][HP_OBF]) // [R24]
        else $error("output full not raised");
    a_ia0_capture: assert property (host_wr_ok |=> ia0 == $past(prev_hp[HP_A0])) // [R25]
        else $error("command select not captured");
    a_ibf_pin: assert property (slave |-> o_pin_out[2][HP_IBE_N] == in_buffer_empty_n) // [R20]
        else $error("input empty pin wrong");
    // status must be clear one clock after host mode ends
    a_mode_off: assert property ($fell(slave) |=> status == 8'h00) // [R26]
        else $error("status not cleared on leaving host mode");
    // a finished host read empties the output buffer unless the cpu refills it
    a_obf_host_clear: assert property (host_rd_end && !obf_set |=> !out_buffer_full) // [R24]
        else $error("output full not cleared by host read");
    // port 1 only drives ones hard while the boost runs
    a_p1_weak_high: assert property ((o_pin_oe[1] & o_pin_out[1] & ~o_strong_pullup[1]) == 8'h00) // [R04]
        else $error("port 1 drove a one outside the boost");
    // bus cycles leave the port 2 latch alone
    a_p2_latch_kept: assert property (i_xbus.act && !slave && !apply |=> $stable(latch[2])) // [R06]
        else $error("port 2 latch changed during bus access");
endmodule

// ===== tb/pport_host_model.sv
`timescale 1ns/1ps

// host processor on the peripheral bus; idle pins are high, same as the pull-ups
module pport_host_model (
    // clock
    input wire logic i_clk,
    // data bus as seen on the pins
    input wire logic [7:0] i_bus,
    // host driven pins of port 2 and the data bus
    output logic [7:0] o_ctl,
    output logic [7:0] o_data,
    output logic o_data_oe
);
    // everything released at start
    initial begin
        o_ctl = 8'hFF;
        o_data = 8'h00;
        o_data_oe = 1'b0;
    end

    // write strobe held lo cycles; select and data held one cycle past its rise
    task automatic write(input logic a0, input logic [7:0] wd, input int lo);
        @(posedge i_clk);
        o_ctl[0] <= a0;
        o_ctl[1] <= 1'b0;
        o_ctl[3] <= 1'b0;
        o_data <= wd;
        o_data_oe <= 1'b1;
        repeat (lo) @(posedge i_clk);
        o_ctl[3] <= 1'b1;
        @(posedge i_clk);
        o_ctl[1] <= 1'b1;
        o_data_oe <= 1'b0;
    endtask

    // read strobe one cycle; dma_grant_n_n low picks the data out register
    task automatic read(input logic a0, input logic dma_grant_n_n, output logic [7:0] rd);
        @(posedge i_clk);
        o_ctl[0] <= a0;
        o_ctl[1] <= 1'b0;
        o_ctl[2] <= 1'b0;
        o_ctl[7] <= dma_grant_n_n;
        @(negedge i_clk);
        rd = i_bus;
        @(posedge i_clk);
        o_ctl[2] <= 1'b1;
        @(posedge i_clk);
        o_ctl[1] <= 1'b1;
        o_ctl[7] <= 1'b1;
    endtask
endmodule

// ===== tb/parallel_port_host_slave_mode_tb.sv
`timescale 1ns/1ps

// self-checking bench for the port block and its host slave mode
module parallel_port_host_slave_mode_tb;
    import pport_pkg::*;
    // clock, reset and core side
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    sfr_req_t special_register = '0;
    xbus_t xb = '0;
    logic [7:0] rdata;
    logic rvalid;
    // pins and outside drivers
    wire [3:0][7:0] pin;
    logic [3:0][7:0] out, oe, sp;
    logic [7:0] ext1 = 8'hFF; // outside drive on port 1
    logic [7:0] flt = 8'h5A; // port 0 has no pull-up, so floating lines wander
    logic [7:0] h_ctl, h_data, d, v, p2v, st;
    logic h_oe;
    logic [31:0] seed = 32'h041e_e90e;
    logic [7:0] q[$];
    int failures = 0;
    int total_checks = 0;
    int sp_cnt;

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) flt <= ~flt;

    // wire levels from every party's enables
    assign pin[0] = (oe[0] & out[0]) | (~oe[0] & (h_oe ? h_data : flt));
    assign pin[1] = (oe[1] & out[1]) | (~oe[1] & ext1);
    assign pin[2] = (oe[2] & out[2]) | (~oe[2] & h_ctl);
    assign pin[3] = (oe[3] & out[3]) | ~oe[3];

    parallel_port_host_slave_mode #(.FIFO_DEPTH(IN_FIFO_DEPTH)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_sfr(special_register), .o_sfr_rdata(rdata), .o_sfr_rvalid(rvalid),
        .i_xbus(xb), .i_pin(pin), .o_pin_out(out), .o_pin_oe(oe), .o_strong_pullup(sp));
    pport_host_model u_host (.i_clk(i_clk), .i_bus(pin[0]), .o_ctl(h_ctl), .o_data(h_data),
        .o_data_oe(h_oe));

    // xorshift source
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // expected status byte from its fields
    function automatic logic [7:0] exp_stat(logic [7:0] u, logic ia0, logic in_buffer_empty_n, logic out_buffer_full);
        return {u[7:4], ia0, u[2], in_buffer_empty_n, out_buffer_full};
    endfunction

    // byte comparison
    task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, exp, got);
        end
    endtask

    // core write; waits out the slot and pin delay while counting port 1 boost cycles
    task automatic cpu_wr(input logic [7:0] a, input logic [7:0] wd);
        @(posedge i_clk);
        special_register.wr <= 1'b1;
        special_register.addr <= a;
        special_register.wdata <= wd;
        @(posedge i_clk);
        special_register.wr <= 1'b0;
        sp_cnt = 0;
        repeat (17) begin
            @(negedge i_clk);
            if (sp[1] !== 8'h00) sp_cnt++;
        end
    endtask

    // core read; answer one clock after the request
    task automatic cpu_rd(input logic [7:0] a, input logic rmw, output logic [7:0] rd);
        @(posedge i_clk);
        special_register.rd <= 1'b1;
        special_register.rmw <= rmw;
        special_register.addr <= a;
        @(posedge i_clk);
        special_register.rd <= 1'b0;
        @(negedge i_clk);
        chk("rvalid", 8'h01, 8'(rvalid));
        rd = rdata;
    endtask

    task automatic end_test(input string n);
        $display("test %s done, %0d mismatches so far", n, failures);
    endtask

    // closing report
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge i_clk);
        failures++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        cpu_rd(PORT_ADDR[1], 1'b1, d);
        chk("p1 latch", LATCH_RESET, d);
        chk("p0 enable", 8'h00, oe[0]);
        end_test("reset");
        // latch writes: read-back, pin level, port 0 low-only drive, boost length
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rnd();
            cpu_wr(PORT_ADDR[1], 8'h00);
            cpu_wr(PORT_ADDR[1], v);
            chk("boost cycles", (v != 8'h00) ? 8'h02 : 8'h00, 8'(sp_cnt));
            cpu_rd(PORT_ADDR[1], 1'b1, d);
            chk("p1 latch", v, d);
            chk("p1 pin", v, pin[1]);
            cpu_wr(PORT_ADDR[0], v);
            chk("p0 enable", ~v, oe[0]);
            chk("p0 drive", 8'h00, out[0] & oe[0]);
        end
        end_test("latch");
        // pin read with the low nibble pulled down outside
        cpu_wr(PORT_ADDR[1], 8'hFF);
        @(posedge i_clk) ext1 <= 8'hF0;
        cpu_rd(PORT_ADDR[1], 1'b0, d);
        chk("p1 pin read", 8'hF0, d);
        cpu_rd(PORT_ADDR[1], 1'b1, d);
        chk("p1 latch read", 8'hFF, d);
        @(posedge i_clk) ext1 <= 8'hFF;
        end_test("pin read");
        // expanded bus: address then data, port 0 latch lost, port 2 kept
        p2v = rnd();
        cpu_wr(PORT_ADDR[2], p2v);
        @(posedge i_clk) xb <= '{1'b1, 1'b1, 1'b0, {rnd(), rnd()}, 8'h00};
        repeat (4) @(negedge i_clk);
        chk("bus addr hi", xb.addr[15:8], pin[2]);
        chk("bus addr lo", xb.addr[7:0], pin[0]);
        @(posedge i_clk) xb <= '{1'b1, 1'b0, 1'b1, xb.addr, rnd()};
        repeat (4) @(negedge i_clk);
        chk("bus data", xb.wdata, pin[0]);
        @(posedge i_clk) xb.act <= 1'b0;
        repeat (14) @(posedge i_clk);
        cpu_rd(PORT_ADDR[0], 1'b1, d);
        chk("p0 latch", LATCH_RESET, d);
        cpu_rd(PORT_ADDR[2], 1'b1, d);
        chk("p2 latch", p2v, d);
        chk("p2 pin", p2v, pin[2]);
        end_test("expanded bus");
        // host mode: user status bits, command write, host status read, pop
        st = rnd();
        cpu_wr(ADDR_HOST_CTRL, 8'h01);
        cpu_wr(ADDR_HOST_STAT, st);
        cpu_rd(ADDR_HOST_STAT, 1'b0, d);
        chk("status", exp_stat(st, 0, 0, 0), d);
        v = rnd();
        u_host.write(1'b1, v, 2);
        repeat (2) @(negedge i_clk);
        chk("ibe pin", 8'h03, 8'({oe[2][HP_IBE_N], out[2][HP_IBE_N]}));
        cpu_rd(ADDR_HOST_STAT, 1'b0, d);
        chk("status", exp_stat(st, 1, 1, 0), d);
        u_host.read(1'b1, 1'b1, d);
        chk("host status", exp_stat(st, 1, 1, 0), d);
        cpu_rd(PORT_ADDR[0], 1'b0, d);
        chk("input buffer", v, d);
        cpu_rd(ADDR_HOST_STAT, 1'b0, d);
        chk("status", exp_stat(st, 1, 0, 0), d);
        end_test("host command");
        // fill past the depth with varied strobe lengths, then drain in order
        q = {};
        for (int i = 0; i <= IN_FIFO_DEPTH; i++) begin
            v = rnd();
            if (i < IN_FIFO_DEPTH) q.push_back(v);
            u_host.write(1'b0, v, 1 + int'(v[1:0]));
        end
        for (int i = 0; i < IN_FIFO_DEPTH; i++) begin
            cpu_rd(PORT_ADDR[0], 1'b0, d);
            chk("input buffer", q[i], d);
        end
        cpu_rd(ADDR_HOST_STAT, 1'b0, d);
        chk("status", exp_stat(st, 0, 0, 0), d);
        chk("ibe pin", 8'h02, 8'({oe[2][HP_IBE_N], out[2][HP_IBE_N]}));
        end_test("input buffer");
        // output buffer with and without dma, read by data select and by grant
        for (int i = 0; i < 2; i++) begin
            cpu_wr(ADDR_HOST_CTRL, (i != 0) ? 8'h03 : 8'h01);
            v = rnd();
            cpu_wr(PORT_ADDR[0], v);
            chk("host pin enables", HP_OUT_MASK, oe[2] & HP_OUT_MASK);
            chk("host pins", (i != 0) ? 8'h50 : 8'h10, out[2] & HP_OUT_MASK);
            cpu_rd(ADDR_HOST_STAT, 1'b0, d);
            chk("status", exp_stat(st, 0, 0, 1), d);
            u_host.read(1'b0, (i != 0) ? 1'b0 : 1'b1, d);
            chk("output buffer", v, d);
            repeat (2) @(negedge i_clk);
            chk("host pins", 8'h00, out[2] & HP_OUT_MASK);
        end
        end_test("output buffer");
        // leaving host mode: port 2 back to its latch, host pins ignored
        cpu_wr(ADDR_HOST_CTRL, 8'h00);
        chk("p2 pin", p2v, pin[2]);
        u_host.write(1'b1, 8'h3C, 1);
        cpu_wr(ADDR_HOST_CTRL, 8'h01);
        cpu_rd(ADDR_HOST_STAT, 1'b0, d);
        chk("status", 8'h00, d);
        end_test("leave host mode");
        wrap_up();
    end
endmodule
